// ==== rtl/sec_pkg.sv ====
// shared constants and types for the small endpoint control block
`default_nettype none
package sec_pkg;
   // register addresses, external memory space
   localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hE65C;
   localparam logic [15:0] ADDR_IRQ_REQUEST = 16'hE65D;
   localparam logic [15:0] ADDR_BC_HIGH = 16'hE68A;
   localparam logic [15:0] ADDR_BC_LOW = 16'hE68B;
   localparam logic [15:0] ADDR_EP1_OUT_COUNT = 16'hE68D;
   localparam logic [15:0] ADDR_EP1_IN_COUNT = 16'hE68F;
   localparam logic [15:0] ADDR_EP0_CTRL = 16'hE6A0;
   localparam logic [15:0] ADDR_EP1_OUT_CTRL = 16'hE6A1;
   localparam logic [15:0] ADDR_EP1_IN_CTRL = 16'hE6A2;
   // special-function space
   localparam logic [15:0] SFR_BUSY_MIRROR = 16'h00BA;

   // control register fields
   localparam int CS_HOLD_BIT = 7;
   localparam int CS_BUSY_BIT = 1;
   localparam int CS_STALL_BIT = 0;
   // interrupt enable / request fields
   localparam int IRQ_SETUP_DATA_BIT = 0;
   localparam int IRQ_SETUP_TOKEN_BIT = 1;
   localparam int IRQ_HS_DONE_BIT = 2;
   localparam int IRQ_COUNT = 3;
   // busy mirror fields
   localparam int MIR_EP0_BIT = 0;
   localparam int MIR_EP1_OUT_BIT = 1;
   localparam int MIR_EP1_IN_BIT = 2;

   // packet size and reset values
   localparam logic [6:0] MAX_PACKET = 7'h40;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_COUNT = 7'h00;

   // answer given to a token
   typedef enum logic [1:0] {SEC_HS_NAK, SEC_HS_ACK, SEC_HS_STALL} sec_hs_t;

   // endpoint zero data stage states
   typedef enum logic [1:0] {SEC_EP0_IDLE, SEC_EP0_ARMED, SEC_EP0_SENDING} sec_ep0_state_t;

   // firmware register access, one byte per cycle
   typedef struct packed {
      logic sfr;
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sec_cpu_req_t;

   // events from the serial interface engine
   typedef struct packed {
      logic setup_token;
      logic setup_stored;
      logic status_done;
      logic ep0_in_ack;
      logic ep0_out_ack;
      logic ep1_in_ack;
      logic ep1_out_ack;
      logic [6:0] rx_count;
   } sec_sie_evt_t;

   // answers towards the serial interface engine
   typedef struct packed {
      sec_hs_t ep0_in;
      sec_hs_t ep0_out;
      sec_hs_t ep0_status;
      sec_hs_t ep1_in;
      sec_hs_t ep1_out;
   } sec_sie_resp_t;

   // endpoint one state
   typedef struct packed {
      logic busy;
      logic stall;
      logic [6:0] count;
      logic fell;
   } sec_ep_one_st_t;

   // control interrupt state
   typedef struct packed {
      logic [IRQ_COUNT-1:0] req;
      logic [IRQ_COUNT-1:0] en;
      logic irq;
   } sec_irq_st_t;

   // main block state
   typedef struct packed {
      sec_ep0_state_t ep0_state;
      logic hold;
      logic ep0_stall;
      logic general;
      logic [7:0] bch;
      logic [7:0] bcl;
      logic [15:0] rem;
      logic [6:0] in_len;
      logic [7:0] rdata;
      logic ep0_in_done;
      logic ep0_out_done;
   } sec_main_st_t;
endpackage
`default_nettype wire

// ==== rtl/sec_ep_one.sv ====
// single-buffered endpoint one: busy, stall and byte count
`default_nettype none
module sec_ep_one #(
   parameter bit LOAD_ON_ARM = 1'b1,
   parameter bit LOAD_ON_DONE = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // firmware side
   input wire logic arm,
   input wire logic [6:0] arm_count,
   input wire logic stall_wr,
   input wire logic stall_val,
   // engine side
   input wire logic done,
   input wire logic [6:0] done_count,
   // status
   output logic busy,
   output logic stall,
   output logic [6:0] count,
   output logic busy_fell,
   output sec_pkg::sec_hs_t hs
);
   sec_pkg::sec_ep_one_st_t q;
   sec_pkg::sec_ep_one_st_t n;

   // next state; arming in the same cycle as completion re-arms
   always_comb begin
      n = q;
      n.fell = 1'b0;
      if (done && q.busy) begin
         n.busy = 1'b0;
         n.fell = 1'b1; // R16 R22
         if (LOAD_ON_DONE) begin
            n.count = done_count; // R21
         end
      end
      if (arm) begin
         n.busy = 1'b1; // R17 R22
         if (LOAD_ON_ARM) begin
            n.count = arm_count;
         end
      end
      if (stall_wr) begin
         n.stall = stall_val;
      end
   end

   // reset leaves the endpoint idle so tokens get NAK
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{busy: 1'b0, stall: 1'b0, count: sec_pkg::RST_COUNT, fell: 1'b0}; // R18 R19
      end else if (ce) begin
         q <= n;
      end
   end

   assign busy = q.busy;
   assign stall = q.stall;
   assign count = q.count;
   assign busy_fell = q.fell;
   // stall overrides everything, else ack while armed
   assign hs = q.stall ? sec_pkg::SEC_HS_STALL :
      (q.busy ? sec_pkg::SEC_HS_ACK : sec_pkg::SEC_HS_NAK); // R20
endmodule
`default_nettype wire

// ==== rtl/sec_irq_flags.sv ====
// control-transfer interrupt enables and sticky requests
`default_nettype none
module sec_irq_flags (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // events
   input wire logic [sec_pkg::IRQ_COUNT-1:0] set,
   // firmware writes
   input wire logic en_wr,
   input wire logic req_wr,
   input wire logic [sec_pkg::IRQ_COUNT-1:0] wdata,
   // state
   output logic [sec_pkg::IRQ_COUNT-1:0] req,
   output logic [sec_pkg::IRQ_COUNT-1:0] en,
   output logic irq
);
   sec_pkg::sec_irq_st_t q;
   sec_pkg::sec_irq_st_t n;

   // write one clears; a new event in the same cycle survives
   always_comb begin
      n = q;
      if (req_wr) begin
         n.req = q.req & ~wdata;
      end
      n.req = n.req | set; // R13
      if (en_wr) begin
         n.en = wdata; // R14
      end
      n.irq = |(n.req & n.en);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else if (ce) begin
         q <= n;
      end
   end

   assign req = q.req;
   assign en = q.en;
   assign irq = q.irq;
endmodule
`default_nettype wire

// ==== rtl/sec_ctrl.sv ====
// small endpoint control: endpoint zero and endpoint one in/out
// Overview of operation
// R1: setup sets hold flag; status NAKed until cleared
// R2: control busy read-only, cleared by setup
// R3: IN0 NAKed until count written; write sets busy
// R4: IN0 acked clears busy, raises IN0 request
// R5: OUT0 NAKed until low count written
// R6: OUT0 acked clears busy, raises OUT0 request
// R7: control stall answers STALL; setup clears it
// R8: firmware sets stall before releasing hold
// R9: 16-bit count; general mode splits into packets
// R10: low count write arms; high byte kept
// R11: OUT0 count reports received bytes, high zero
// R12: firmware initialises high count after reset
// R13: setup token, setup data, handshake interrupts
// R14: enables and requests in separate registers
// R15: mirror register shows three busy flags
// R16: OUT1 busy clears after ack, raises request
// R17: any OUT1 count write arms, sets busy
// R18: OUT1 busy zero after reset
// R19: IN1 busy zero after reset
// R20: endpoint one stall answers STALL
// R21: OUT1 count is 7-bit received bytes
// R22: IN1 count write arms; ack clears, requests
`default_nettype none
module sec_ctrl (
   // clock, enable and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic reset,
   // firmware register port
   input wire sec_pkg::sec_cpu_req_t cpu,
   output logic [7:0] cpu_rdata,
   // setup block pointer in general mode
   input wire logic setup_block_ptr_general,
   // serial interface engine
   input wire sec_pkg::sec_sie_evt_t sie,
   output sec_pkg::sec_sie_resp_t resp,
   output logic [6:0] ep0_in_len,
   // interrupt requests
   output logic ctrl_irq,
   output logic ep0_in_irq,
   output logic ep0_out_irq,
   output logic ep1_in_irq,
   output logic ep1_out_irq
);
   sec_pkg::sec_main_st_t q;
   sec_pkg::sec_main_st_t n;

   // decoded strobes
   logic wr_ctrl;
   logic wr_bch;
   logic wr_bcl;
   logic wr_ie;
   logic wr_irq;
   logic wr_o1_cnt;
   logic wr_i1_cnt;
   logic wr_o1_cs;
   logic wr_i1_cs;

   // endpoint one status
   logic o1_busy;
   logic o1_stall;
   logic [6:0] o1_count;
   logic i1_busy;
   logic i1_stall;
   logic [6:0] i1_count;

   // interrupt block
   logic [sec_pkg::IRQ_COUNT-1:0] irq_set;
   logic [sec_pkg::IRQ_COUNT-1:0] irq_req;
   logic [sec_pkg::IRQ_COUNT-1:0] irq_en;

   logic ep0_busy;

   // endpoint one answers, merged into the engine response below
   sec_pkg::sec_hs_t o1_hs;
   sec_pkg::sec_hs_t i1_hs;

   // register images for the read path; busy bits are views only
   logic [7:0] mirror_img;
   logic [7:0] ep0_cs_img;
   logic [7:0] o1_cs_img;
   logic [7:0] i1_cs_img;

   // address match in either space
   function automatic logic hit(input sec_pkg::sec_cpu_req_t r, input logic sfr, input logic [15:0] a);
      hit = (r.sfr == sfr) && (r.addr == a);
   endfunction

   // control byte of an endpoint, each flag in its own field
   function automatic logic [7:0] cs_img(input logic hold, input logic busy, input logic stall);
      cs_img = 8'h00;
      cs_img[sec_pkg::CS_HOLD_BIT] = hold;
      cs_img[sec_pkg::CS_BUSY_BIT] = busy;
      cs_img[sec_pkg::CS_STALL_BIT] = stall;
   endfunction

   // write strobes
   always_comb begin
      wr_ctrl = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_EP0_CTRL);
      wr_bch = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_BC_HIGH);
      wr_bcl = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_BC_LOW);
      wr_ie = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_IRQ_ENABLE);
      wr_irq = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_IRQ_REQUEST);
      wr_o1_cnt = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_EP1_OUT_COUNT);
      wr_i1_cnt = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_EP1_IN_COUNT);
      wr_o1_cs = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_EP1_OUT_CTRL);
      wr_i1_cs = cpu.wr && hit(cpu, 1'b0, sec_pkg::ADDR_EP1_IN_CTRL);
   end

   // busy covers the armed and the multi-packet sending phase
   assign ep0_busy = (q.ep0_state != sec_pkg::SEC_EP0_IDLE);

   // status images; the mirror lets firmware poll all three busy flags at once
   always_comb begin
      mirror_img = 8'h00;
      mirror_img[sec_pkg::MIR_EP0_BIT] = ep0_busy; // R15
      mirror_img[sec_pkg::MIR_EP1_OUT_BIT] = o1_busy; // R15
      mirror_img[sec_pkg::MIR_EP1_IN_BIT] = i1_busy; // R15
      ep0_cs_img = cs_img(q.hold, ep0_busy, q.ep0_stall); // R2
      o1_cs_img = cs_img(1'b0, o1_busy, o1_stall);
      i1_cs_img = cs_img(1'b0, i1_busy, i1_stall);
   end

   // the three control-transfer interrupt sources
   always_comb begin
      irq_set = '0;
      irq_set[sec_pkg::IRQ_SETUP_TOKEN_BIT] = sie.setup_token; // R13
      irq_set[sec_pkg::IRQ_SETUP_DATA_BIT] = sie.setup_stored; // R13
      irq_set[sec_pkg::IRQ_HS_DONE_BIT] = sie.status_done; // R13
   end

   sec_irq_flags u_irq (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .set(irq_set),
      .en_wr(wr_ie),
      .req_wr(wr_irq),
      .wdata(cpu.wdata[sec_pkg::IRQ_COUNT-1:0]),
      .req(irq_req),
      .en(irq_en),
      .irq(ctrl_irq)
   );

   // out endpoint: count comes from the engine, any write arms
   sec_ep_one #(
      .LOAD_ON_ARM(1'b0),
      .LOAD_ON_DONE(1'b1)
   ) u_ep1_out (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .arm(wr_o1_cnt),
      .arm_count(cpu.wdata[6:0]),
      .stall_wr(wr_o1_cs),
      .stall_val(cpu.wdata[sec_pkg::CS_STALL_BIT]),
      .done(sie.ep1_out_ack),
      .done_count(sie.rx_count),
      .busy(o1_busy),
      .stall(o1_stall),
      .count(o1_count),
      .busy_fell(ep1_out_irq),
      .hs(o1_hs)
   );

   // in endpoint: count comes from the firmware write
   sec_ep_one #(
      .LOAD_ON_ARM(1'b1),
      .LOAD_ON_DONE(1'b0)
   ) u_ep1_in (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .arm(wr_i1_cnt),
      .arm_count(cpu.wdata[6:0]),
      .stall_wr(wr_i1_cs),
      .stall_val(cpu.wdata[sec_pkg::CS_STALL_BIT]),
      .done(sie.ep1_in_ack),
      .done_count(sie.rx_count),
      .busy(i1_busy),
      .stall(i1_stall),
      .count(i1_count),
      .busy_fell(ep1_in_irq),
      .hs(i1_hs)
   );

   // endpoint zero state and register read path
   always_comb begin
      n = q;
      n.ep0_in_done = 1'b0;
      n.ep0_out_done = 1'b0;

      // in data acked; general mode keeps sending until the block is gone
      if (sie.ep0_in_ack && ep0_busy) begin
         if (!q.general || q.rem <= {9'h000, sec_pkg::MAX_PACKET}) begin
            n.ep0_state = sec_pkg::SEC_EP0_IDLE; // R4
            n.ep0_in_done = 1'b1; // R4
            n.rem = 16'h0000;
         end else begin
            n.ep0_state = sec_pkg::SEC_EP0_SENDING; // R9
            n.rem = q.rem - {9'h000, sec_pkg::MAX_PACKET}; // R9
         end
      end

      // out data acked only while plainly armed, not mid-block
      if (sie.ep0_out_ack && q.ep0_state == sec_pkg::SEC_EP0_ARMED) begin
         n.ep0_state = sec_pkg::SEC_EP0_IDLE; // R6
         n.ep0_out_done = 1'b1; // R6
         n.bch = sec_pkg::RST_BYTE; // R11
         n.bcl = {1'b0, sie.rx_count}; // R11
      end

      // control register: hold is write-one-to-clear, busy is read-only
      if (wr_ctrl) begin
         if (cpu.wdata[sec_pkg::CS_HOLD_BIT]) begin
            n.hold = 1'b0; // R1
         end
         n.ep0_stall = cpu.wdata[sec_pkg::CS_STALL_BIT]; // R7
      end

      // high byte is just stored; it arms nothing
      if (wr_bch) begin
         n.bch = cpu.wdata; // R10
      end

      // low byte arms both directions; the host picks which
      if (wr_bcl) begin
         n.bcl = cpu.wdata;
         n.rem = {q.bch, cpu.wdata}; // R9 R10
         n.general = setup_block_ptr_general; // R9
         n.ep0_state = sec_pkg::SEC_EP0_ARMED; // R3 R5
      end

      // a setup token overrides hold, stall, data stage state and general mode in its cycle
      if (sie.setup_token) begin
         n.hold = 1'b1; // R1
         n.ep0_stall = 1'b0; // R7
         n.ep0_state = sec_pkg::SEC_EP0_IDLE; // R2
         n.general = 1'b0;
      end

      // length of the next in packet, capped at one max packet
      if (n.rem > {9'h000, sec_pkg::MAX_PACKET}) begin
         n.in_len = sec_pkg::MAX_PACKET; // R9
      end else begin
         n.in_len = n.rem[6:0];
      end

      // read data is registered; unmapped addresses read zero
      if (cpu.rd) begin
         n.rdata = 8'h00;
         if (hit(cpu, 1'b1, sec_pkg::SFR_BUSY_MIRROR)) begin
            n.rdata = mirror_img; // R15
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_EP0_CTRL)) begin
            n.rdata = ep0_cs_img; // R2
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_BC_HIGH)) begin
            n.rdata = q.bch;
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_BC_LOW)) begin
            n.rdata = q.bcl;
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_IRQ_ENABLE)) begin
            n.rdata[sec_pkg::IRQ_COUNT-1:0] = irq_en; // R14
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_IRQ_REQUEST)) begin
            n.rdata[sec_pkg::IRQ_COUNT-1:0] = irq_req; // R14
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_EP1_OUT_CTRL)) begin
            n.rdata = o1_cs_img;
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_EP1_IN_CTRL)) begin
            n.rdata = i1_cs_img;
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_EP1_OUT_COUNT)) begin
            n.rdata = {1'b0, o1_count}; // R21
         end
         if (hit(cpu, 1'b0, sec_pkg::ADDR_EP1_IN_COUNT)) begin
            n.rdata = {1'b0, i1_count};
         end
      end
   end

   // high count byte is cleared here too, though firmware must not rely on it
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{ep0_state: sec_pkg::SEC_EP0_IDLE, hold: 1'b0, ep0_stall: 1'b0, general: 1'b0,
                bch: sec_pkg::RST_BYTE, bcl: sec_pkg::RST_BYTE, rem: 16'h0000, in_len: sec_pkg::RST_COUNT,
                rdata: sec_pkg::RST_BYTE, ep0_in_done: 1'b0, ep0_out_done: 1'b0};
      end else if (ce) begin
         q <= n;
      end
   end

   // outputs
   assign cpu_rdata = q.rdata;
   assign ep0_in_len = q.in_len;
   assign ep0_in_irq = q.ep0_in_done;
   assign ep0_out_irq = q.ep0_out_done;

   // endpoint zero answers: stall first, then armed or held; one process drives the whole response
   always_comb begin
      resp.ep1_in = i1_hs; // R20 R22
      resp.ep1_out = o1_hs; // R17 R20
      if (q.ep0_stall) begin
         resp.ep0_in = sec_pkg::SEC_HS_STALL; // R7
         resp.ep0_out = sec_pkg::SEC_HS_STALL; // R7
         resp.ep0_status = sec_pkg::SEC_HS_STALL; // R7
      end else begin
         resp.ep0_in = ep0_busy ? sec_pkg::SEC_HS_ACK : sec_pkg::SEC_HS_NAK; // R3
         resp.ep0_out = (q.ep0_state == sec_pkg::SEC_EP0_ARMED) ? sec_pkg::SEC_HS_ACK : sec_pkg::SEC_HS_NAK; // R5
         resp.ep0_status = q.hold ? sec_pkg::SEC_HS_NAK : sec_pkg::SEC_HS_ACK; // R1
      end
   end
endmodule
`default_nettype wire

// ==== sim/sec_ctrl_checker.sv ====
// concurrent checks on the ports of the small endpoint control block
`default_nettype none
module sec_ctrl_checker (
   // clock and reset
   input wire logic clk,
   input wire logic ce,
   input wire logic reset,
   // firmware port
   input wire sec_pkg::sec_cpu_req_t cpu,
   input wire logic [7:0] cpu_rdata,
   input wire logic setup_block_ptr_general,
   // engine side
   input wire sec_pkg::sec_sie_evt_t sie,
   input wire sec_pkg::sec_sie_resp_t resp,
   input wire logic [6:0] ep0_in_len,
   // interrupt outputs
   input wire logic ctrl_irq,
   input wire logic ep0_in_irq,
   input wire logic ep0_out_irq,
   input wire logic ep1_in_irq,
   input wire logic ep1_out_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // decoded firmware writes, memory space only, and the setup token strobe
   wire logic wr_x = ce && cpu.wr && !cpu.sfr;
   wire logic arm_in1 = wr_x && cpu.addr == sec_pkg::ADDR_EP1_IN_COUNT;
   wire logic arm_out1 = wr_x && cpu.addr == sec_pkg::ADDR_EP1_OUT_COUNT;
   wire logic stall_in1 = wr_x && cpu.addr == sec_pkg::ADDR_EP1_IN_CTRL && cpu.wdata[0];
   wire logic cs_wr = wr_x && cpu.addr == sec_pkg::ADDR_EP0_CTRL;
   wire logic tok = ce && sie.setup_token;
   // status stage still held off three cycles after setup when firmware has not touched the control register
   chk_hold_on_setup: assert property (tok ##1 !cs_wr [*3] |-> resp.ep0_status == sec_pkg::SEC_HS_NAK)
      else $error("status stage not held after setup");
   chk_setup_unarms: assert property (tok |=> resp.ep0_in == sec_pkg::SEC_HS_NAK)
      else $error("endpoint zero in not idle after setup");
   chk_setup_out_idle: assert property (tok |=> resp.ep0_out == sec_pkg::SEC_HS_NAK)
      else $error("endpoint zero out not idle after setup");
   chk_in1_arms: assert property (arm_in1 |=> resp.ep1_in != sec_pkg::SEC_HS_NAK)
      else $error("in one count write did not arm");
   chk_out1_arms: assert property (arm_out1 |=> resp.ep1_out != sec_pkg::SEC_HS_NAK)
      else $error("out one count write did not arm");
   chk_in1_stall: assert property (stall_in1 |=> resp.ep1_in == sec_pkg::SEC_HS_STALL)
      else $error("in one stall not answered");
   chk_in1_done: assert property (ep1_in_irq |-> $past(sie.ep1_in_ack) ##1 !ep1_in_irq)
      else $error("in one request without ack");
   chk_out1_done: assert property (ep1_out_irq |-> $past(sie.ep1_out_ack))
      else $error("out one request without ack");
   chk_ep0_in_done: assert property (ep0_in_irq |-> $past(sie.ep0_in_ack))
      else $error("zero in request without ack");
   chk_ep0_out_done: assert property (ep0_out_irq |-> $past(sie.ep0_out_ack))
      else $error("zero out request without ack");
   chk_pkt_limit: assert property (ep0_in_len <= sec_pkg::MAX_PACKET)
      else $error("packet length above maximum");
   chk_reset_idle: assert property ($fell(reset) |-> resp.ep1_in == sec_pkg::SEC_HS_NAK
      && resp.ep1_out == sec_pkg::SEC_HS_NAK)
      else $error("endpoint one not idle after reset");
   // main scenarios reached
   cov_in1: cover property (ep1_in_irq);
   cov_out0: cover property (ep0_out_irq);
   cov_setup: cover property (tok);
endmodule
bind sec_ctrl sec_ctrl_checker chk_i (.clk, .ce, .reset, .cpu, .cpu_rdata, .setup_block_ptr_general,
   .sie, .resp, .ep0_in_len, .ctrl_irq, .ep0_in_irq, .ep0_out_irq, .ep1_in_irq, .ep1_out_irq);
`default_nettype wire

// ==== sim/sec_host_model.sv ====
// host and engine events as seen by the endpoint control block
`default_nettype none
module sec_host_model (
   // clock
   input wire logic clk,
   // event pulses
   output var sec_pkg::sec_sie_evt_t sie
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sie = '0;
   // one event pulse after d idle cycles; count line scrambled once released
   task automatic ev(input int k, input logic [6:0] n, input int d);
      sec_pkg::sec_sie_evt_t e;
      e = '0;
      e[7+k] = 1'b1;
      e.rx_count = n;
      repeat (d) @(posedge clk);
      @(posedge clk);
      sie <= e;
      @(posedge clk);
      sie <= {7'h00, ~n};
      #1;
   endtask
endmodule
`default_nettype wire

// ==== sim/sec_ctrl_test.sv ====
// self-checking bench for the small endpoint control block
`default_nettype none
module sec_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SETUP = 6, STORED = 5, DONE = 4, IN0 = 3, OUT0 = 2, IN1 = 1, OUT1 = 0;
   localparam logic [7:0] NAK = 8'(sec_pkg::SEC_HS_NAK);
   localparam logic [7:0] ACK = 8'(sec_pkg::SEC_HS_ACK);
   localparam logic [7:0] STL = 8'(sec_pkg::SEC_HS_STALL);
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic gen = 1'b0;
   logic ce = 1'b1;
   sec_pkg::sec_cpu_req_t cpu = '0;
   sec_pkg::sec_sie_evt_t sie;
   sec_pkg::sec_sie_resp_t resp;
   logic [7:0] cpu_rdata;
   logic [6:0] len;
   logic [4:0] irq;
   int n_errors = 0;
   int checks = 0;
   always #20 clk = ~clk;
   // clock enable driven by the bench; one scenario freezes the block
   sec_ctrl dut (.clk(clk), .ce(ce), .reset(reset), .cpu(cpu), .cpu_rdata(cpu_rdata),
      .setup_block_ptr_general(gen), .sie(sie), .resp(resp), .ep0_in_len(len), .ctrl_irq(irq[4]),
      .ep0_in_irq(irq[3]), .ep0_out_irq(irq[2]), .ep1_in_irq(irq[1]), .ep1_out_irq(irq[0]));
   sec_host_model host (.clk(clk), .sie(sie));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one register access: request held for one taking edge
   task automatic acc(input logic s, input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      cpu <= '{sfr: s, wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      cpu <= '0;
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(1'b0, 1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, 1'b0, a, 8'h00);
      chk(cpu_rdata, e);
   endtask
   task automatic mir(input logic [7:0] e);
      acc(1'b1, 1'b0, sec_pkg::SFR_BUSY_MIRROR, 8'h00);
      chk(cpu_rdata, e);
   endtask
   task automatic conclude();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      mir(8'h00);
      rd(sec_pkg::ADDR_EP0_CTRL, 8'h00);
      wr(sec_pkg::ADDR_BC_HIGH, 8'h00);
      // endpoint zero in, single packet
      chk(8'(resp.ep0_in), NAK);
      wr(sec_pkg::ADDR_BC_LOW, 8'h08);
      chk(8'(resp.ep0_in), ACK);
      mir(8'h01);
      wr(sec_pkg::ADDR_EP0_CTRL, 8'h00);
      rd(sec_pkg::ADDR_EP0_CTRL, 8'h02);
      host.ev(IN0, 7'h00, 2);
      chk(8'(irq[3:0]), 8'h08);
      mir(8'h00);
      // endpoint zero out
      wr(sec_pkg::ADDR_BC_LOW, 8'hFF);
      chk(8'(resp.ep0_out), ACK);
      host.ev(OUT0, 7'h0C, 0);
      chk(8'(irq[3:0]), 8'h04);
      rd(sec_pkg::ADDR_BC_LOW, 8'h0C);
      rd(sec_pkg::ADDR_BC_HIGH, 8'h00);
      $display("test endpoint zero data done");
      // setup with stall and armed data stage pending
      wr(sec_pkg::ADDR_IRQ_ENABLE, 8'h07);
      wr(sec_pkg::ADDR_EP0_CTRL, 8'h01);
      wr(sec_pkg::ADDR_BC_LOW, 8'h00);
      host.ev(SETUP, 7'h00, 0);
      chk(8'(resp.ep0_status), NAK);
      host.ev(STORED, 7'h00, 3);
      rd(sec_pkg::ADDR_EP0_CTRL, 8'h80);
      rd(sec_pkg::ADDR_IRQ_REQUEST, 8'h03);
      chk(8'(irq[4]), 8'h01);
      wr(sec_pkg::ADDR_EP0_CTRL, 8'h01);
      wr(sec_pkg::ADDR_EP0_CTRL, 8'h81);
      chk(8'(resp.ep0_status), STL);
      rd(sec_pkg::ADDR_EP0_CTRL, 8'h01);
      wr(sec_pkg::ADDR_EP0_CTRL, 8'h00);
      chk(8'(resp.ep0_status), ACK);
      wr(sec_pkg::ADDR_IRQ_REQUEST, 8'h03);
      host.ev(DONE, 7'h00, 0);
      rd(sec_pkg::ADDR_IRQ_REQUEST, 8'h04);
      wr(sec_pkg::ADDR_IRQ_ENABLE, 8'h00);
      rd(sec_pkg::ADDR_IRQ_ENABLE, 8'h00);
      chk(8'(irq[4]), 8'h00);
      $display("test setup done");
      // endpoint one in and out
      wr(sec_pkg::ADDR_EP1_IN_COUNT, 8'h05);
      chk(8'(resp.ep1_in), ACK);
      mir(8'h04);
      host.ev(IN1, 7'h00, 1);
      chk(8'(irq[3:0]), 8'h02);
      chk(8'(resp.ep1_in), NAK);
      wr(sec_pkg::ADDR_EP1_OUT_COUNT, 8'h00);
      mir(8'h02);
      host.ev(OUT1, 7'h40, 0);
      chk(8'(irq[3:0]), 8'h01);
      rd(sec_pkg::ADDR_EP1_OUT_COUNT, 8'h40);
      mir(8'h00);
      for (int i = 0; i < 2; i++) begin
         wr(sec_pkg::ADDR_EP1_OUT_CTRL + 16'(i), 8'h01);
         chk(i == 1 ? 8'(resp.ep1_in) : 8'(resp.ep1_out), STL);
         rd(sec_pkg::ADDR_EP1_OUT_CTRL + 16'(i), 8'h01);
         wr(sec_pkg::ADDR_EP1_OUT_CTRL + 16'(i), 8'h00);
         chk(i == 1 ? 8'(resp.ep1_in) : 8'(resp.ep1_out), NAK);
      end
      wr(16'hE6A3, 8'hFF);
      rd(16'hE6A3, 8'h00);
      $display("test endpoint one done");
      // block mode: 130 bytes go out as 64, 64, 2
      @(posedge clk) gen <= 1'b1;
      wr(sec_pkg::ADDR_BC_HIGH, 8'h00);
      wr(sec_pkg::ADDR_BC_LOW, 8'h82);
      mir(8'h01);
      for (int i = 0; i < 3; i++) begin
         chk(8'(len), i < 2 ? 8'h40 : 8'h02);
         host.ev(IN0, 7'h00, 0);
         chk(8'(irq[3:0]), i == 2 ? 8'h08 : 8'h00);
      end
      $display("test block mode done");
      // clock enable low: a write is not taken and no flag moves
      @(posedge clk) ce <= 1'b0;
      wr(sec_pkg::ADDR_EP1_IN_COUNT, 8'h05);
      @(posedge clk) ce <= 1'b1;
      mir(8'h00);
      $display("test clock enable done");
      // reset in mid-run drops an armed endpoint
      wr(sec_pkg::ADDR_EP1_IN_COUNT, 8'h40);
      wr(sec_pkg::ADDR_EP1_OUT_COUNT, 8'h00);
      @(posedge clk) reset <= 1'b1;
      @(posedge clk) reset <= 1'b0;
      mir(8'h00);
      chk(8'(resp.ep1_out), NAK);
      $display("test reset done");
      conclude();
   end
endmodule
`default_nettype wire
